// ### hw/srr_regs.sv
// status reporting register set driven by decoded instrument commands
// commands are taken on a rising edge with valid and ready both high;
// a query answer stands two edges later for one cycle; the answer data
// are reloaded every cycle and only mean something while valid is high
// the status byte is registered, so it lags its sources by one edge;
// that costs a cycle but a poll never sees a byte caught mid-update
// the event registers are cleared by their own query, and a new event
// in that same cycle survives, so no event is ever lost to a read
`timescale 1ns/1ns
module srr_regs
  import srr_pkg::*;
#(
  parameter int ERR_W = SRR_ERR_W,
  parameter int ERR_DEPTH = SRR_ERR_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_cmd_valid,
  input wire srr_cmd_t i_cmd_op,
  input wire logic [15:0] i_cmd_data,
  input wire logic [15:0] i_ques_set,
  input wire logic [7:0] i_std_set,
  input wire logic i_err_valid,
  input wire logic [ERR_W-1:0] i_err_code,
  input wire logic i_msg_avail,
  input wire logic i_nv_psc,
  input wire logic [7:0] i_nv_sb_mask,
  input wire logic [7:0] i_nv_std_mask,
  output logic o_cmd_ready,
  output logic o_rsp_valid,
  output logic [15:0] o_rsp_data,
  output logic [7:0] o_status_byte,
  output logic o_err_full,
  output logic o_psc,
  output logic [7:0] o_sb_mask,
  output logic [7:0] o_std_mask
);
  localparam int AW = $clog2(ERR_DEPTH);
  localparam logic [AW:0] CNT_FULL = (AW+1)'(ERR_DEPTH);
  localparam logic [AW:0] CNT_ZERO = '0;
  localparam logic [AW:0] CNT_ONE = (AW+1)'(1);
  localparam logic [AW-1:0] PTR_ZERO = '0;
  localparam logic [AW-1:0] PTR_ONE = AW'(1);

  srr_state_t state_q;
  logic [15:0] ques_q;
  logic [15:0] ques_mask_q;
  logic [7:0] std_flags_q;
  logic [7:0] std_mask_q;
  logic [7:0] sb_mask_q;
  logic psc_q;
  logic [7:0] stb_q;
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] cnt_q;
  logic p1_valid_q;
  logic p1_err_q;
  logic p1_err_hit_q;
  logic [15:0] p1_data_q;
  logic rsp_valid_q;
  logic [15:0] rsp_data_q;
  logic [ERR_W-1:0] mem_rd_data;

  // command code match, shared by all the take strobes
  function automatic logic op_is(input srr_cmd_t op, input srr_cmd_t code);
    return op == code;
  endfunction

  // command decode, taken only once the power-up load is done
  wire run = (state_q == SRR_ST_RUN);
  wire go = i_cmd_valid & run;
  wire rd_ques = go & op_is(i_cmd_op, SRR_CMD_QUES_EVENT_Q);
  wire wr_ques_mask = go & op_is(i_cmd_op, SRR_CMD_QUES_MASK_W);
  wire do_preset = go & op_is(i_cmd_op, SRR_CMD_PRESET);
  wire do_clear = go & op_is(i_cmd_op, SRR_CMD_CLEAR);
  wire wr_std_mask = go & op_is(i_cmd_op, SRR_CMD_STD_MASK_W);
  wire rd_std = go & op_is(i_cmd_op, SRR_CMD_STD_FLAGS_Q);
  wire do_opc = go & op_is(i_cmd_op, SRR_CMD_OPC);
  wire wr_psc = go & op_is(i_cmd_op, SRR_CMD_PSC_W);
  wire wr_sb_mask = go & op_is(i_cmd_op, SRR_CMD_SB_MASK_W);
  wire rd_err = go & op_is(i_cmd_op, SRR_CMD_ERR_Q);
  wire is_query = go & (
    rd_ques | rd_std | rd_err |
    op_is(i_cmd_op, SRR_CMD_QUES_MASK_Q) |
    op_is(i_cmd_op, SRR_CMD_STD_MASK_Q) |
    op_is(i_cmd_op, SRR_CMD_OPC_Q) |
    op_is(i_cmd_op, SRR_CMD_PSC_Q) |
    op_is(i_cmd_op, SRR_CMD_SB_MASK_Q) |
    op_is(i_cmd_op, SRR_CMD_STB_Q));

  // event registers: a new event in a clearing cycle still lands
  wire [15:0] ques_base = (do_clear | rd_ques) ? SRR_ZERO16 : ques_q;
  wire [15:0] ques_d = ques_base | (i_ques_set & SRR_QUES_USED);
  wire [7:0] opc_hit = do_opc ? 8'(1 << SRR_OPC_BIT) : SRR_ZERO8;
  wire [7:0] std_base = (do_clear | rd_std) ? SRR_ZERO8 : std_flags_q;
  wire [7:0] std_d = std_base | ((i_std_set | opc_hit) & SRR_STD_USED);

  // written values lose their unused positions before they are stored
  wire [15:0] ques_mask_wr = i_cmd_data & SRR_QUES_USED;
  wire [7:0] std_mask_wr = i_cmd_data[7:0] & SRR_STD_USED;
  wire [7:0] sb_mask_wr = i_cmd_data[7:0] & SRR_SB_USED;

  // mask next values; the power-up load comes from the stored settings
  wire [15:0] ques_mask_d = do_preset ? SRR_ZERO16 :
    wr_ques_mask ? ques_mask_wr : ques_mask_q;
  wire [7:0] nv_std = i_nv_psc ? SRR_ZERO8 : (i_nv_std_mask & SRR_STD_USED);
  wire [7:0] nv_sb = i_nv_psc ? SRR_ZERO8 : (i_nv_sb_mask & SRR_SB_USED);
  wire [7:0] std_mask_d = !run ? nv_std :
    wr_std_mask ? std_mask_wr : std_mask_q;
  wire [7:0] sb_mask_d = !run ? nv_sb :
    wr_sb_mask ? sb_mask_wr : sb_mask_q;
  wire psc_d = !run ? i_nv_psc : wr_psc ? i_cmd_data[0] : psc_q;

  // error queue bookkeeping; a clear frees room for a same-cycle push
  wire err_full = (cnt_q == CNT_FULL);
  wire err_empty = (cnt_q == CNT_ZERO);
  wire push = i_err_valid & (do_clear | ~err_full);
  wire pop = rd_err & ~err_empty;
  wire [AW-1:0] wr_addr = do_clear ? PTR_ZERO : wr_ptr_q;
  wire [AW-1:0] wr_ptr_d = push ? wr_addr + PTR_ONE : wr_addr;
  wire [AW-1:0] rd_ptr_d = do_clear ? PTR_ZERO :
    pop ? rd_ptr_q + PTR_ONE : rd_ptr_q;
  wire [AW:0] cnt_d = do_clear ? (push ? CNT_ONE : CNT_ZERO) :
    cnt_q + (push ? CNT_ONE : CNT_ZERO) - (pop ? CNT_ONE : CNT_ZERO);

  // status byte summary bits from current events and masks
  wire [7:0] stb_low;
  assign stb_low[1:0] = 2'h0;
  assign stb_low[SRR_STB_ERR] = ~err_empty;
  assign stb_low[SRR_STB_QUES] = |(ques_q & ques_mask_q);
  assign stb_low[SRR_STB_MAV] = i_msg_avail;
  assign stb_low[SRR_STB_ESB] = |(std_flags_q & std_mask_q);
  assign stb_low[7:6] = 2'h0;
  wire mss = |(stb_low & sb_mask_q);
  wire [7:0] stb_d = stb_low | (8'(mss) << SRR_STB_MSS);

  // reply value for everything but the error queue, binary weights
  wire [15:0] reply =
    (i_cmd_op == SRR_CMD_QUES_EVENT_Q) ? ques_q :
    (i_cmd_op == SRR_CMD_QUES_MASK_Q) ? ques_mask_q :
    (i_cmd_op == SRR_CMD_STD_MASK_Q) ? {8'h00, std_mask_q} :
    (i_cmd_op == SRR_CMD_STD_FLAGS_Q) ? {8'h00, std_flags_q} :
    (i_cmd_op == SRR_CMD_OPC_Q) ? SRR_OPC_REPLY :
    (i_cmd_op == SRR_CMD_PSC_Q) ? {15'h0000, psc_q} :
    (i_cmd_op == SRR_CMD_SB_MASK_Q) ? {8'h00, sb_mask_q} :
    (i_cmd_op == SRR_CMD_STB_Q) ? {8'h00, stb_q} :
    SRR_ZERO16;
  // empty queue answers zero rather than stale memory
  wire [15:0] final_data = !p1_err_q ? p1_data_q :
    p1_err_hit_q ? 16'(mem_rd_data) : SRR_ZERO16;

  srr_err_mem #(
    .W(ERR_W),
    .DEPTH(ERR_DEPTH),
    .AW(AW)
  ) u_err_mem (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_wr_en(push),
    .i_wr_addr(wr_addr),
    .i_wr_data(i_err_code),
    .i_rd_addr(rd_ptr_q),
    .o_rd_data(mem_rd_data)
  );

  // one cycle of power-up load, then commands are taken
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_q <= SRR_ST_INIT;
    end
    else
    begin
      case (state_q)
        SRR_ST_INIT: state_q <= SRR_ST_RUN;
        SRR_ST_RUN: state_q <= SRR_ST_RUN;
        default: state_q <= SRR_ST_INIT;
      endcase
    end
  end

  // event registers and the registered status byte
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ques_q <= SRR_ZERO16;
      std_flags_q <= SRR_ZERO8;
      stb_q <= SRR_ZERO8;
    end
    else
    begin
      ques_q <= ques_d;
      std_flags_q <= std_d;
      stb_q <= stb_d;
    end
  end

  // masks and the power-on clear setting
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ques_mask_q <= SRR_ZERO16;
      std_mask_q <= SRR_ZERO8;
      sb_mask_q <= SRR_ZERO8;
      psc_q <= SRR_PSC_RESET;
    end
    else
    begin
      ques_mask_q <= ques_mask_d;
      std_mask_q <= std_mask_d;
      sb_mask_q <= sb_mask_d;
      psc_q <= psc_d;
    end
  end

  // queue write pointer
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wr_ptr_q <= PTR_ZERO;
    end
    else
    begin
      wr_ptr_q <= wr_ptr_d;
    end
  end

  // read pointer and fill count; a pop moves both, a push moves only the count
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rd_ptr_q <= PTR_ZERO;
      cnt_q <= CNT_ZERO;
    end
    else
    begin
      rd_ptr_q <= rd_ptr_d;
      cnt_q <= cnt_d;
    end
  end

  // first reply stage, so queue reads share the memory's register delay
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      p1_valid_q <= 1'b0;
      p1_err_q <= 1'b0;
      p1_err_hit_q <= 1'b0;
      p1_data_q <= SRR_ZERO16;
    end
    else
    begin
      p1_valid_q <= is_query;
      p1_err_q <= rd_err;
      p1_err_hit_q <= pop;
      p1_data_q <= reply;
    end
  end

  // second stage drives the reply ports straight from flip-flops
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rsp_valid_q <= 1'b0;
      rsp_data_q <= SRR_ZERO16;
    end
    else
    begin
      rsp_valid_q <= p1_valid_q;
      rsp_data_q <= final_data;
    end
  end

  assign o_cmd_ready = run;
  assign o_rsp_valid = rsp_valid_q;
  assign o_rsp_data = rsp_data_q;
  assign o_status_byte = stb_q;
  assign o_err_full = err_full;
  assign o_psc = psc_q;
  assign o_sb_mask = sb_mask_q;
  assign o_std_mask = std_mask_q;
endmodule

// ### hw/srr_pkg.sv
// constants, commands and states for the status reporting registers
package srr_pkg;
  localparam int SRR_QW = 16;
  localparam int SRR_SW = 8;
  localparam int SRR_ERR_W = 16;
  localparam int SRR_ERR_DEPTH = 16;
  // bit positions that carry meaning in each register
  localparam logic [15:0] SRR_QUES_USED = 16'h3a03;
  localparam logic [7:0] SRR_STD_USED = 8'hbd;
  localparam logic [7:0] SRR_SB_USED = 8'h38;
  // field positions
  localparam int SRR_OPC_BIT = 0;
  localparam int SRR_STB_ERR = 2;
  localparam int SRR_STB_QUES = 3;
  localparam int SRR_STB_MAV = 4;
  localparam int SRR_STB_ESB = 5;
  localparam int SRR_STB_MSS = 6;
  // fixed reply values and reset values
  localparam logic [15:0] SRR_OPC_REPLY = 16'h0001;
  localparam logic [15:0] SRR_ZERO16 = 16'h0000;
  localparam logic [7:0] SRR_ZERO8 = 8'h00;
  localparam logic SRR_PSC_RESET = 1'b0;
  // command codes on the command port
  typedef enum logic [3:0] {
    SRR_CMD_QUES_EVENT_Q,
    SRR_CMD_QUES_MASK_W,
    SRR_CMD_QUES_MASK_Q,
    SRR_CMD_PRESET,
    SRR_CMD_CLEAR,
    SRR_CMD_STD_MASK_W,
    SRR_CMD_STD_MASK_Q,
    SRR_CMD_STD_FLAGS_Q,
    SRR_CMD_OPC,
    SRR_CMD_OPC_Q,
    SRR_CMD_PSC_W,
    SRR_CMD_PSC_Q,
    SRR_CMD_SB_MASK_W,
    SRR_CMD_SB_MASK_Q,
    SRR_CMD_STB_Q,
    SRR_CMD_ERR_Q
  } srr_cmd_t;
  typedef enum logic {
    SRR_ST_INIT,
    SRR_ST_RUN
  } srr_state_t;
endpackage

// ### hw/srr_err_mem.sv
// storage for the pending error queue, registered read port
`timescale 1ns/1ns
module srr_err_mem #(
  parameter int W = 16,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_wr_en,
  input wire logic [AW-1:0] i_wr_addr,
  input wire logic [W-1:0] i_wr_data,
  input wire logic [AW-1:0] i_rd_addr,
  output logic [W-1:0] o_rd_data
);
  logic [W-1:0] mem_q [DEPTH];

  // array itself has no reset; contents are only read behind the count
  always_ff @(posedge i_clk)
  begin
    if (i_wr_en)
    begin
      mem_q[i_wr_addr] <= i_wr_data;
    end
  end

  // read data always from a register
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_rd_data <= '0;
    end
    else
    begin
      o_rd_data <= mem_q[i_rd_addr];
    end
  end
endmodule

// ### tb/srr_host.sv
// host model offering one instrument command at a time
`timescale 1ns/1ns
module srr_host
  import srr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_ready,
  output logic o_valid,
  output srr_cmd_t o_op,
  output logic [15:0] o_data
);
  initial
  begin
    o_valid = 1'b0;
    o_op = SRR_CMD_STB_Q;
    o_data = 16'h0000;
  end
  // called at a falling edge; holds the offer until it is taken
  task automatic send(input srr_cmd_t op, input logic [15:0] d);
    o_valid = 1'b1;
    o_op = op;
    o_data = d;
    while (!i_ready)
      @(negedge i_clk);
    @(posedge i_clk);
    @(negedge i_clk);
  endtask
  // released data is scrambled so stale values never look valid
  task automatic idle;
    o_valid = 1'b0;
    o_data = ~o_data;
  endtask
endmodule

// ### tb/srr_regs_props.sv
// concurrent checks on the status register ports
`timescale 1ns/1ns
module srr_regs_props
  import srr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_cmd_valid,
  input wire srr_cmd_t i_cmd_op,
  input wire logic [15:0] i_cmd_data,
  input wire logic o_cmd_ready,
  input wire logic o_rsp_valid,
  input wire logic [15:0] o_rsp_data,
  input wire logic [7:0] o_status_byte,
  input wire logic [7:0] o_sb_mask,
  input wire logic [7:0] o_std_mask
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  // one-hot take strobe per command code
  wire logic tv = i_cmd_valid & o_cmd_ready;
  wire logic [15:0] tk = {16{tv}} & (16'h0001 << i_cmd_op);
  wire logic [7:0] wd = i_cmd_data[7:0];
  property p_opc_q;
    tk[SRR_CMD_OPC_Q] |-> ##2 o_rsp_valid && o_rsp_data == SRR_OPC_REPLY;
  endproperty
  a_opc_q: assert property (p_opc_q) else $error("opc reply");
  property p_sb_w;
    tk[SRR_CMD_SB_MASK_W] |=> o_sb_mask == ($past(wd) & SRR_SB_USED);
  endproperty
  a_sb_w: assert property (p_sb_w) else $error("sb mask write");
  property p_std_w;
    tk[SRR_CMD_STD_MASK_W] |=> o_std_mask == ($past(wd) & SRR_STD_USED);
  endproperty
  a_std_w: assert property (p_std_w) else $error("std mask write");
  property p_sb_q;
    tk[SRR_CMD_SB_MASK_Q] |-> ##2 o_rsp_valid
      && o_rsp_data == {8'h00, $past(o_sb_mask, 2)};
  endproperty
  a_sb_q: assert property (p_sb_q) else $error("sb mask reply");
  property p_std_q;
    tk[SRR_CMD_STD_MASK_Q] |-> ##2 o_rsp_valid
      && o_rsp_data == {8'h00, $past(o_std_mask, 2)};
  endproperty
  a_std_q: assert property (p_std_q) else $error("std mask reply");
  property p_opc;
    tk[SRR_CMD_OPC] && o_std_mask[0] |-> ##2 o_status_byte[5];
  endproperty
  a_opc: assert property (p_opc) else $error("opc summary");
  property p_preset;
    tk[SRR_CMD_PRESET] |-> ##2 !o_status_byte[3];
  endproperty
  a_preset: assert property (p_preset) else $error("preset mask");
  // stable mask avoids the one-cycle lag after a mask write
  property p_sum;
    $stable(o_sb_mask) |->
      o_status_byte[6] == |(o_status_byte[5:0] & o_sb_mask[5:0]);
  endproperty
  a_sum: assert property (p_sum) else $error("summary bit");
  c_opc: cover property (tk[SRR_CMD_OPC] ##2 o_status_byte[5]);
  c_sum: cover property (o_status_byte[6]);
  c_rsp: cover property (tk[SRR_CMD_STB_Q] ##2 o_rsp_valid);
endmodule

// ### tb/test_status_reporting_registers.sv
// self-checking bench for the status reporting registers
`timescale 1ns/1ns
module test_status_reporting_registers
  import srr_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, msg = 1'b0, ev = 1'b0, nvp = 1'b0;
  logic cv, rdy, rv, full, psc, mp, mr;
  srr_cmd_t op;
  logic [15:0] cd, rd, mq, mqm, qs = 16'h0000, ec = 16'h0000;
  logic [7:0] stb, sbm, sdm, ms, mse, msb, mst, pst, lf = 8'h2d;
  logic [7:0] ss = 8'h00, nsb = 8'hff, nsd = 8'hff;
  logic [16:0] e;
  logic [15:0] eq[$], xq[$];
  int bad_count = 0, checks_done = 0;
  always #5 clk = ~clk;
  srr_host host_u (.i_clk(clk), .i_ready(rdy), .o_valid(cv), .o_op(op),
    .o_data(cd));
  srr_regs dut_u (.i_clk(clk), .i_resetn(rst_n), .i_cmd_valid(cv),
    .i_cmd_op(op), .i_cmd_data(cd), .i_ques_set(qs), .i_std_set(ss),
    .i_err_valid(ev), .i_err_code(ec), .i_msg_avail(msg), .i_nv_psc(nvp),
    .i_nv_sb_mask(nsb), .i_nv_std_mask(nsd), .o_cmd_ready(rdy),
    .o_rsp_valid(rv), .o_rsp_data(rd), .o_status_byte(stb),
    .o_err_full(full), .o_psc(psc), .o_sb_mask(sbm), .o_std_mask(sdm));
  function automatic logic [7:0] nx(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic chk(input string n, input logic [7:0] s, x);
    checks_done++;
    if (s !== x)
    begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", n, x, s);
    end
  endtask
  task automatic chkr(input logic [15:0] s);
    logic [16:0] x;
    x = xq.size() ? {1'b0, xq.pop_front()} : 17'h10000;
    checks_done++;
    if ({1'b0, s} !== x)
    begin
      bad_count++;
      $display("[ERR] reply exp %h got %h", x, s);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // reference model; status byte lags the state by one edge
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      {mq, mqm, ms, mse, msb, mst, mp, mr} = '0;
      eq = {};
      xq = {};
    end
    else
    begin
      pst = mst;
      mst = {2'b00, |(ms & mse), msg, |(mq & mqm), eq.size() != 0, 2'b00};
      mst[6] = |(mst & msb);
      if (!mr)
      begin
        mr = 1'b1;
        mp = nvp;
        msb = nvp ? 8'h00 : nsb & SRR_SB_USED;
        mse = nvp ? 8'h00 : nsd & SRR_STD_USED;
      end
      else if (cv)
      begin
        case (op)
          SRR_CMD_QUES_EVENT_Q: e = {1'b0, mq};
          SRR_CMD_QUES_MASK_Q: e = {1'b0, mqm};
          SRR_CMD_STD_MASK_Q: e = 17'(mse);
          SRR_CMD_STD_FLAGS_Q: e = 17'(ms);
          SRR_CMD_OPC_Q: e = 17'h00001;
          SRR_CMD_PSC_Q: e = 17'(mp);
          SRR_CMD_SB_MASK_Q: e = 17'(msb);
          SRR_CMD_STB_Q: e = 17'(pst);
          SRR_CMD_ERR_Q: e = eq.size() ? {1'b0, eq.pop_front()} : '0;
          default: e = 17'h10000;
        endcase
        if (!e[16])
          xq.push_back(e[15:0]);
        if (op == SRR_CMD_CLEAR)
          eq = {};
        case (op)
          SRR_CMD_QUES_EVENT_Q: mq = '0;
          SRR_CMD_QUES_MASK_W: mqm = cd & SRR_QUES_USED;
          SRR_CMD_PRESET: mqm = '0;
          SRR_CMD_CLEAR: {mq, ms} = '0;
          SRR_CMD_STD_MASK_W: mse = cd[7:0] & SRR_STD_USED;
          SRR_CMD_STD_FLAGS_Q: ms = '0;
          SRR_CMD_OPC: ms[0] = 1'b1;
          SRR_CMD_PSC_W: mp = cd[0];
          SRR_CMD_SB_MASK_W: msb = cd[7:0] & SRR_SB_USED;
          default: ;
        endcase
      end
      mq = mq | (qs & SRR_QUES_USED);
      ms = ms | (ss & SRR_STD_USED);
      if (ev && eq.size() < 16)
        eq.push_back(ec);
    end
  // ready must stay low until the power-up load is done
  always @(negedge clk)
    if (rst_n)
      chk("ready", 8'(rdy), 8'(mr));
  // outputs settle after the rising edge, so compare on the falling one
  always @(negedge clk)
    if (rst_n && mr)
    begin
      chk("status", stb, mst);
      chk("sb_mask", sbm, msb);
      chk("std_mask", sdm, mse);
      chk("psc_full", {6'h00, psc, full}, {6'h00, mp, eq.size() == 16});
      if (rv)
        chkr(rd);
    end
  // power-on cases, error queue, every command, then random traffic
  initial
  begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    rst_n = 1'b0;
    nvp = 1'b1;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    $display("test power_on done");
    for (int i = 0; i < 18; i++)
    begin
      ev = 1'b1;
      ec = 16'(i + 1);
      @(negedge clk);
    end
    ev = 1'b0;
    host_u.send(SRR_CMD_ERR_Q, 16'h0000);
    host_u.send(SRR_CMD_CLEAR, 16'h0000);
    host_u.send(SRR_CMD_ERR_Q, 16'h0000);
    $display("test error_queue done");
    for (int i = 0; i < 216; i++)
    begin
      lf = nx(lf);
      qs = lf[7] ? {lf, ~lf} : 16'h0000;
      ss = lf[6] ? lf : 8'h00;
      msg = lf[5];
      host_u.send(i < 16 ? srr_cmd_t'(i) : srr_cmd_t'(lf[3:0] ^ lf[7:4]),
        {lf, nx(lf)});
    end
    qs = 16'h0000;
    ss = 8'h00;
    host_u.idle();
    repeat (4) @(negedge clk);
    chk("pending", 8'(xq.size()), 8'h00);
    $display("test commands done");
    results();
  end
  // watchdog far beyond the few hundred cycles the tests need
  initial
  begin
    #50000;
    bad_count++;
    results();
  end
endmodule
bind srr_regs srr_regs_props props_u (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_cmd_valid(i_cmd_valid), .i_cmd_op(i_cmd_op), .i_cmd_data(i_cmd_data),
  .o_cmd_ready(o_cmd_ready), .o_rsp_valid(o_rsp_valid),
  .o_rsp_data(o_rsp_data), .o_status_byte(o_status_byte),
  .o_sb_mask(o_sb_mask), .o_std_mask(o_std_mask));
